// >>> shared/slir_pkg.sv
// Constants and carrier types for the status lock and identification read block.
// Assumes a mode 0 or mode 3 serial host and a free-running system clock.
package slir_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Opcodes
  localparam logic [7:0] SLIR_ID_OP_A = 8'h90;
  localparam logic [7:0] SLIR_ID_OP_B = 8'hAB;
  localparam logic [7:0] SLIR_STATUS_WRITE_OP_DEF = 8'h01;
  localparam logic [7:0] SLIR_STATUS_ARM_OP_DEF = 8'h50;

  ////////////////////////////////////////////////////////////////////////////
  // Bit counts within one frame
  localparam int SLIR_CNT_W = 6;
  localparam logic [5:0] SLIR_BITS_ZERO = 6'h00;
  localparam logic [5:0] SLIR_BITS_ONE = 6'h01;
  localparam logic [5:0] SLIR_BITS_OPCODE = 6'h08;
  localparam logic [5:0] SLIR_BITS_DATA = 6'h10;
  localparam logic [5:0] SLIR_BITS_ID = 6'h20;
  localparam logic [5:0] SLIR_BITS_SAT = 6'h21;
  localparam logic [2:0] SLIR_BIT_MSB = 3'h7;
  localparam logic [2:0] SLIR_BIT_LSB = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions in the status byte
  localparam int SLIR_LOCK_POS = 7;
  localparam int SLIR_BP_HI_POS = 3;
  localparam int SLIR_BP_LO_POS = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic lock;
    logic bp_hi;
    logic bp_lo;
  } slir_status_type;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] data;
    logic [5:0] bits;
    logic addr_lsb;
    logic id_op;
  } slir_frame_type;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam slir_status_type SLIR_STATUS_RESET = '{lock: 1'b0, bp_hi: 1'b0, bp_lo: 1'b0};
  localparam slir_frame_type SLIR_FRAME_RESET = '{
    opcode: 8'h00, data: 8'h00, bits: 6'h00, addr_lsb: 1'b0, id_op: 1'b0};

endpackage : slir_pkg

// >>> verilog/slir_status_lock_id.sv
// Status lock-down write and identification read command handling.
// Assumes spi_sck stands still while spi_cs_n is high, and spi_cs_n stays
// high for at least four sys_clk periods between frames.
//
// Summary of operation
// - Status write changes only the two protect bits and the lock bit.
// - Status write ignored while write-protect pin low and lock bit set.
// - With write-protect low, lock bit may go 0 to 1 only.
// - With write-protect high, lock and both protect bits change freely.
// - Permission judged from lock bit and pin level before select rises.
// - One permitted write may set lock and change protect bits together.
// - Status update happens only at the rising edge of chip select.
// - Identification read: one of two opcodes, then 24 address bits MSB first.
// - Address zero gives manufacturer code, address one gives device code.
// - Identification output alternates between both codes until select rises.
// - Arming instruction is discarded unless a status write or another arming follows next.
`timescale 1ns/1ps

module slir_status_lock_id #(
  parameter logic [7:0] STATUS_WRITE_OP = slir_pkg::SLIR_STATUS_WRITE_OP_DEF,
  parameter logic [7:0] STATUS_ARM_OP = slir_pkg::SLIR_STATUS_ARM_OP_DEF,
  // Arbitrary value
  parameter logic [7:0] MANUFACTURER_CODE = 8'hC3,
  // Arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h3C
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe_n,
  input wire logic wp_n,
  output logic block_protect_hi,
  output logic block_protect_lo,
  output logic protect_lock_bit,
  output logic status_write_done,
  output logic arm_pending
);

  ////////////////////////////////////////////////////////////////////////////
  // Link side: capture on rising spi_sck

  // Clears the per-frame state as soon as select goes high
  logic link_clr;
  assign link_clr = reset | spi_cs_n;

  logic first_q;
  logic frame_tgl_q;
  logic [7:0] shift_q;
  slir_pkg::slir_frame_type frame_q;
  slir_pkg::slir_frame_type frame_d;

  logic [7:0] shift_next;
  logic [5:0] cnt_cur;
  logic [5:0] cnt_next;
  logic op_is_id;

  // Counter restarts on the first edge of every frame
  assign cnt_cur = first_q ? slir_pkg::SLIR_BITS_ZERO : frame_q.bits;
  assign cnt_next = (cnt_cur == slir_pkg::SLIR_BITS_SAT) ? cnt_cur :
                    6'(cnt_cur + slir_pkg::SLIR_BITS_ONE);
  assign shift_next = {shift_q[6:0], spi_si};
  assign op_is_id = (shift_next == slir_pkg::SLIR_ID_OP_A) ||
                    (shift_next == slir_pkg::SLIR_ID_OP_B);

  always_comb begin
    frame_d = frame_q;
    frame_d.bits = cnt_next;
    if (cnt_next == slir_pkg::SLIR_BITS_OPCODE) begin
      frame_d.opcode = shift_next;
      frame_d.id_op = op_is_id;
    end
    if (cnt_next == slir_pkg::SLIR_BITS_DATA) begin
      frame_d.data = shift_next;
    end
    if (cnt_next == slir_pkg::SLIR_BITS_ID) begin
      frame_d.addr_lsb = spi_si;
    end
  end

  always_ff @(posedge spi_sck or posedge link_clr) begin
    if (link_clr) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  // Frame record survives select rising so the system side can read it
  always_ff @(posedge spi_sck or posedge reset) begin
    if (reset) begin
      frame_q <= slir_pkg::SLIR_FRAME_RESET;
      shift_q <= 8'h00;
    end else begin
      frame_q <= frame_d;
      shift_q <= shift_next;
    end
  end

  // One toggle per frame with at least one clock edge; it crosses through a
  // plain two-stage synchroniser, the record itself is held still meanwhile
  always_ff @(posedge spi_sck or posedge reset) begin
    if (reset) begin
      frame_tgl_q <= 1'b0;
    end else begin
      frame_tgl_q <= first_q ? ~frame_tgl_q : frame_tgl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link side: identification output on falling spi_sck

  logic started_q;
  logic sel_q;
  logic [2:0] bit_q;
  logic so_q;
  logic so_oe_n_q;

  logic id_mode;
  logic cur_sel;
  logic [2:0] cur_bit;
  logic [7:0] cur_code;
  logic [2:0] bit_next;
  logic sel_next;

  // Stale counts of the previous frame are masked until the first edge
  assign id_mode = ~first_q && frame_q.id_op && (frame_q.bits >= slir_pkg::SLIR_BITS_ID);
  assign cur_sel = started_q ? sel_q : frame_q.addr_lsb;
  assign cur_bit = started_q ? bit_q : slir_pkg::SLIR_BIT_MSB;
  assign cur_code = cur_sel ? DEVICE_CODE : MANUFACTURER_CODE;
  assign bit_next = 3'(cur_bit - 3'h1);
  assign sel_next = (cur_bit == slir_pkg::SLIR_BIT_LSB) ? ~cur_sel : cur_sel;

  // A leading falling edge in mode 3 finds id_mode low and does nothing
  always_ff @(negedge spi_sck or posedge link_clr) begin
    if (link_clr) begin
      started_q <= 1'b0;
      sel_q <= 1'b0;
      bit_q <= slir_pkg::SLIR_BIT_MSB;
      so_q <= 1'b0;
      so_oe_n_q <= 1'b1;
    end else if (id_mode) begin
      started_q <= 1'b1;
      sel_q <= sel_next;
      bit_q <= bit_next;
      so_q <= cur_code[cur_bit];
      so_oe_n_q <= 1'b0;
    end
  end

  assign spi_so = so_q;
  assign spi_so_oe_n = so_oe_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // System side: synchronisers

  // Select gets a third stage for its edge detector, and the pin gets one
  // too, so that the level judged is the one seen while select was low
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic wp_s1_q;
  logic wp_s2_q;
  logic wp_s3_q;
  logic tgl_s1_q;
  logic tgl_s2_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= spi_cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  // Held as protected until the pin has been seen after reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wp_s1_q <= 1'b0;
      wp_s2_q <= 1'b0;
      wp_s3_q <= 1'b0;
    end else begin
      wp_s1_q <= wp_n;
      wp_s2_q <= wp_s1_q;
      wp_s3_q <= wp_s2_q;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
    end else begin
      tgl_s1_q <= frame_tgl_q;
      tgl_s2_q <= tgl_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System side: state

  typedef enum logic [0:0] {
    SLIR_ARM_IDLE = 1'b0,
    SLIR_ARM_SET = 1'b1
  } slir_arm_state_type;

  slir_pkg::slir_status_type status_q;
  slir_pkg::slir_status_type status_d;
  slir_pkg::slir_status_type status_new;
  slir_arm_state_type arm_state_q;
  slir_arm_state_type arm_state_d;
  logic done_q;
  logic tgl_seen_q;

  ////////////////////////////////////////////////////////////////////////////
  // System side: frame end decode

  logic cs_rise;
  logic new_frame;
  logic opcode_full;
  logic data_full;
  logic frame_is_arm;
  logic frame_is_write;
  logic armed;
  logic lock_held;
  logic write_ok;

  // The frame record is quiet here: spi_sck is idle while select is high
  assign cs_rise = cs_s2_q & ~cs_s3_q;
  // A frame without a single clock edge leaves no trace, not even a disarm
  assign new_frame = cs_rise && (tgl_s2_q != tgl_seen_q);
  assign opcode_full = frame_q.bits >= slir_pkg::SLIR_BITS_OPCODE;
  assign data_full = frame_q.bits >= slir_pkg::SLIR_BITS_DATA;
  assign frame_is_arm = opcode_full && (frame_q.opcode == STATUS_ARM_OP);
  assign frame_is_write = data_full && (frame_q.opcode == STATUS_WRITE_OP);
  assign armed = (arm_state_q == SLIR_ARM_SET);
  // Pin level as it stood in the last sample with select still low
  assign lock_held = ~wp_s3_q & status_q.lock;
  assign write_ok = new_frame && armed && frame_is_write && ~lock_held;

  ////////////////////////////////////////////////////////////////////////////
  // System side: status update and arming

  // Only these three bits exist here; other status bits are untouched
  assign status_new.lock = frame_q.data[slir_pkg::SLIR_LOCK_POS];
  assign status_new.bp_hi = frame_q.data[slir_pkg::SLIR_BP_HI_POS];
  assign status_new.bp_lo = frame_q.data[slir_pkg::SLIR_BP_LO_POS];
  // Locked with pin low never reaches write_ok, so a clear cannot happen
  assign status_d = write_ok ? status_new : status_q;

  // Any later complete frame other than another arming spends or discards the arming
  always_comb begin
    arm_state_d = arm_state_q;
    unique case (arm_state_q)
      SLIR_ARM_IDLE: begin
        if (new_frame && frame_is_arm) begin
          arm_state_d = SLIR_ARM_SET;
        end
      end
      SLIR_ARM_SET: begin
        if (new_frame && !frame_is_arm) begin
          arm_state_d = SLIR_ARM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      status_q <= slir_pkg::SLIR_STATUS_RESET;
      done_q <= 1'b0;
    end else begin
      status_q <= status_d;
      done_q <= write_ok;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      arm_state_q <= SLIR_ARM_IDLE;
      tgl_seen_q <= 1'b0;
    end else begin
      arm_state_q <= arm_state_d;
      tgl_seen_q <= cs_rise ? tgl_s2_q : tgl_seen_q;
    end
  end

  assign block_protect_hi = status_q.bp_hi;
  assign block_protect_lo = status_q.bp_lo;
  assign protect_lock_bit = status_q.lock;
  assign status_write_done = done_q;
  assign arm_pending = armed;

endmodule : slir_status_lock_id

// >>> test/slir_checker.sv
// Checker: port-level assertions for the status lock and id block.
// Assumes wp_n holds steady around every frame end.
`timescale 1ns/1ps
module slir_checker (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic spi_cs_n,
  input wire logic spi_so,
  input wire logic spi_so_oe_n,
  input wire logic wp_n,
  input wire logic block_protect_hi,
  input wire logic block_protect_lo,
  input wire logic protect_lock_bit,
  input wire logic status_write_done,
  input wire logic arm_pending
);
  wire logic [2:0] st = {protect_lock_bit, block_protect_hi, block_protect_lo};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_pulse;
    status_write_done ##1 !status_write_done;
  endsequence
  property p_change_done;
    $changed(st) |-> s_pulse;
  endproperty
  a_change_done: assert property (p_change_done)
    else $error("status moved without done pulse");
  property p_done_cs;
    status_write_done |-> $past(spi_cs_n, 3);
  endproperty
  a_done_cs: assert property (p_done_cs)
    else $error("done without select high");
  property p_armed;
    $changed(st) |-> $past(arm_pending, 2);
  endproperty
  a_armed: assert property (p_armed)
    else $error("status moved without arming");
  property p_locked;
    $changed(st) |-> wp_n || !$past(protect_lock_bit);
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked status changed");
  property p_lock_fall;
    $fell(protect_lock_bit) |-> $past(wp_n, 4);
  endproperty
  a_lock_fall: assert property (p_lock_fall)
    else $error("lock cleared with wp low");
  property p_arm_drop;
    status_write_done |-> ##[0:1] !arm_pending;
  endproperty
  a_arm_drop: assert property (p_arm_drop)
    else $error("arming not consumed");
  property p_idle_out;
    spi_cs_n |-> spi_so_oe_n && !spi_so;
  endproperty
  a_idle_out: assert property (p_idle_out)
    else $error("output active while deselected");
  property p_frame_stable;
    !spi_cs_n && !$past(spi_cs_n) |-> $stable(st);
  endproperty
  a_frame_stable: assert property (p_frame_stable)
    else $error("status moved inside frame");
endmodule : slir_checker

bind slir_status_lock_id slir_checker u_chk (.sys_clk(sys_clk), .reset(reset),
  .spi_cs_n(spi_cs_n), .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n), .wp_n(wp_n),
  .block_protect_hi(block_protect_hi), .block_protect_lo(block_protect_lo),
  .protect_lock_bit(protect_lock_bit), .status_write_done(status_write_done),
  .arm_pending(arm_pending));

// >>> test/slir_host.sv
// Host model: serial master, 160 ns clock, idle low between frames.
// Waits 400 ns after each frame, so the caller needs no gap of its own.
`timescale 1ns/1ps
module slir_host (
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_si,
  input wire logic spi_so
);
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
  end
  // Sends n bits from the top of tx; rx keeps the last 16 bits seen
  task automatic xfer(input logic [47:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    #13 spi_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      spi_si = tx[47-i];
      #80 spi_sck = 1'b1;
      rx = {rx[14:0], spi_so};
      #80 spi_sck = 1'b0;
    end
    #40 spi_cs_n = 1'b1;
    spi_si = ~spi_si;
    #400;
  endtask : xfer
endmodule : slir_host

// >>> test/slir_status_lock_id_tb.sv
// Bench: lock-down status writes and identification reads.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
module slir_status_lock_id_tb;
  // Arbitrary identity codes
  localparam logic [7:0] MFR = 8'hC3;
  localparam logic [7:0] DEV = 8'h3C;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic wp_n = 1'b1;
  wire spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe_n;
  wire bp_hi, bp_lo, lock, done, armed;
  logic [2:0] exp_st = 3'h0;
  logic [15:0] rx;
  int bad_count = 0;
  int n_compared = 0;
  int n_done = 0;
  int exp_done = 0;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (done === 1'b1) n_done++;
  slir_status_lock_id #(.MANUFACTURER_CODE(MFR), .DEVICE_CODE(DEV)) dut (
    .sys_clk(sys_clk), .reset(reset), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n), .wp_n(wp_n),
    .block_protect_hi(bp_hi), .block_protect_lo(bp_lo), .protect_lock_bit(lock),
    .status_write_done(done), .arm_pending(armed));
  slir_host host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic arm, input logic wp, input logic [7:0] d);
    @(posedge sys_clk) wp_n <= wp;
    if (arm) begin
      host.xfer({slir_pkg::SLIR_STATUS_ARM_OP_DEF, 40'h0}, 8, rx);
      chk("arm_pending", 16'h1, 16'(armed));
    end
    host.xfer({slir_pkg::SLIR_STATUS_WRITE_OP_DEF, d, 32'h0}, 16, rx);
    if (arm && (wp || !exp_st[2])) begin
      exp_st = {d[7], d[3], d[2]};
      exp_done++;
    end
    chk("status", 16'(exp_st), 16'({lock, bp_hi, bp_lo}));
    chk("done pulses", 16'(exp_done), 16'(n_done));
  endtask : wr
  task automatic t_free;
    wr(1'b1, 1'b1, 8'h8C);
    wr(1'b1, 1'b1, 8'h73);
  endtask : t_free
  task automatic t_lockdown;
    wr(1'b1, 1'b1, 8'h84);
    wr(1'b1, 1'b0, 8'h00);
    wr(1'b1, 1'b0, 8'h0C);
    wr(1'b1, 1'b1, 8'h00);
  endtask : t_lockdown
  // Unarmed write, then arming spoiled by a frame in between
  task automatic t_unarmed;
    wr(1'b0, 1'b1, 8'h8C);
    host.xfer({slir_pkg::SLIR_STATUS_ARM_OP_DEF, 40'h0}, 8, rx);
    chk("arm_pending", 16'h1, 16'(armed));
    host.xfer({slir_pkg::SLIR_ID_OP_A, 40'h0}, 32, rx);
    chk("arm_pending", 16'h0, 16'(armed));
    wr(1'b0, 1'b1, 8'h8C);
  endtask : t_unarmed
  task automatic t_lock_set;
    wr(1'b1, 1'b0, 8'h88);
    wr(1'b1, 1'b1, 8'h00);
  endtask : t_lock_set
  task automatic t_id;
    logic [7:0] ops [2] = '{slir_pkg::SLIR_ID_OP_A, slir_pkg::SLIR_ID_OP_B};
    for (int i = 0; i < 4; i++) begin
      host.xfer({ops[i/2], 23'h0, i[0], 16'h0}, 48, rx);
      chk("id bytes", i[0] ? {DEV, MFR} : {MFR, DEV}, rx);
    end
    chk("idle output", 16'h2, 16'({spi_so_oe_n, spi_so}));
  endtask : t_id
  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("reset status", 16'h0, 16'({lock, bp_hi, bp_lo}));
    t_free();
    t_lockdown();
    t_unarmed();
    t_lock_set();
    t_id();
    tally_and_finish();
  end
  // Run needs about 85 us; a hang is cut well after that
  initial begin
    #1000000;
    bad_count++;
    tally_and_finish();
  end
endmodule : slir_status_lock_id_tb
